// ===== rtl/startup_seq_pkg.sv
// Purpose: shared constants for the configuration startup sequencer
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes:   phase selections use small codes; see field constants below
package startup_seq_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] STAT_ADDR = 4'h4;

	// ----------------------------------------------------------------
	// control fields
	// ----------------------------------------------------------------
	localparam int DONE_LSB  = 0;
	localparam int GTS_LSB   = 4;
	localparam int GWE_LSB   = 8;
	localparam int LOCK_LSB  = 12;
	localparam int MATCH_LSB = 16;
	localparam int PIPE_BIT  = 20;
	localparam int CALIO_BIT = 21;
	localparam int START_BIT = 24;

	// stored bits of the control word; start is a self-clearing strobe
	localparam logic [31:0] CTRL_MASK  = 32'h003f_7ff7;
	localparam logic [31:0] CTRL_RESET = 32'h0008_7654;

	// ----------------------------------------------------------------
	// selection codes
	// ----------------------------------------------------------------
	localparam logic [3:0] SEL_DONE    = 4'h7;
	localparam logic [3:0] SEL_KEEP    = 4'h8;
	localparam logic [3:0] SEL_NO_STALL_OPTION  = 4'h7;
	localparam logic [3:0] SEL_AUTO    = 4'h8;
	localparam logic [2:0] PHASE_FIRST = 3'h0;
	localparam logic [2:0] PHASE_LAST  = 3'h6;
	localparam logic [2:0] PHASE_END   = 3'h7;
	localparam logic [2:0] DONE_DFLT   = 3'h4;
	localparam logic [3:0] AUTO_MATCH  = 4'h2;

	// ----------------------------------------------------------------
	// status fields
	// ----------------------------------------------------------------
	localparam int ST_PHASE_LSB = 0;
	localparam int ST_DONE_BIT  = 4;
	localparam int ST_GTS_BIT   = 5;
	localparam int ST_GWE_BIT   = 6;
	localparam int ST_LOCK_BIT  = 7;
	localparam int ST_MATCH_BIT = 8;
	localparam int ST_STATE_LSB = 10;

	typedef enum logic [1:0] {
		SEQ_IDLE     = 2'b00,
		SEQ_RUN      = 2'b01,
		SEQ_COMPLETE = 2'b10
	} seq_state_t;

endpackage

// ===== rtl/pin_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_mclk,
	input  wire logic             i_reset,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			meta_q <= '0;
			o_sync <= '0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end

endmodule

// ===== rtl/config_startup_sequencer.sv
// Purpose: startup phase sequencer run after configuration load
// Assumes: configuration clock, lock and match arrive on pins
// Notes:   one phase per configuration clock rising edge
`timescale 1ns/10ps
module config_startup_sequencer (
	input  wire logic        i_mclk,
	input  wire logic        i_reset,
	input  wire logic        i_cclk,
	input  wire logic        i_lock,
	input  wire logic        i_match,
	input  wire logic [3:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	input  wire logic [3:0]  i_byteenable,
	output logic             o_waitrequest,
	output logic [31:0]      o_readdata,
	output logic             o_done,
	output logic             o_io_tristate,
	output logic             o_write_enable,
	output logic             o_bram_enable
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge_be(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// phase select 0..6 reached, or done/keep codes
	function automatic logic sel_reached(input logic [3:0] sel, input logic [2:0] ph,
		input logic done_now);
		logic r;
		r = 1'b0;
		if (sel <= {1'b0, startup_seq_pkg::PHASE_LAST}) begin
			r = ({1'b0, ph} >= sel);
		end else if (sel == startup_seq_pkg::SEL_DONE) begin
			r = done_now;
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// pin inputs
	// ----------------------------------------------------------------
	logic [2:0] sync_w;
	logic       cclk_s;
	logic       lock_s;
	logic       match_s;
	logic       cclk_prev_q;
	logic       tick;

	pin_sync #(.WIDTH(3)) u_sync (
		.i_mclk  (i_mclk),
		.i_reset (i_reset),
		.i_async ({i_cclk, i_lock, i_match}),
		.o_sync  (sync_w)
	);

	assign cclk_s  = sync_w[2];
	assign lock_s  = sync_w[1];
	assign match_s = sync_w[0];
	assign tick    = cclk_s & ~cclk_prev_q;

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	logic [31:0] ctrl_q;
	logic [31:0] ctrl_d;
	logic        wait_d;
	logic [31:0] rdata_d;
	logic        req;
	logic        wr_now;
	logic        start;
	logic [31:0] status;

	assign req    = i_read | i_write;
	assign wr_now = i_write & ~o_waitrequest & (i_address == startup_seq_pkg::CTRL_ADDR);
	assign start  = wr_now & i_byteenable[3] & i_writedata[startup_seq_pkg::START_BIT];

	always_comb begin
		wait_d  = 1'b1;
		rdata_d = o_readdata;
		ctrl_d  = ctrl_q;
		if (req && o_waitrequest) begin
			wait_d  = 1'b0;
			rdata_d = 32'h0000_0000;
			if (i_read && i_address == startup_seq_pkg::CTRL_ADDR) begin
				rdata_d = ctrl_q;
			end else if (i_read && i_address == startup_seq_pkg::STAT_ADDR) begin
				rdata_d = status;
			end
		end
		if (wr_now) begin
			ctrl_d = merge_be(ctrl_q, i_writedata, i_byteenable) & startup_seq_pkg::CTRL_MASK;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			o_waitrequest <= 1'b1;
			o_readdata    <= 32'h0000_0000;
			ctrl_q        <= startup_seq_pkg::CTRL_RESET;
			cclk_prev_q   <= 1'b0;
		end else begin
			o_waitrequest <= wait_d;
			o_readdata    <= rdata_d;
			ctrl_q        <= ctrl_d;
			cclk_prev_q   <= cclk_s;
		end
	end

	// ----------------------------------------------------------------
	// selection decode
	// ----------------------------------------------------------------
	logic [2:0] done_sel;
	logic [3:0] gts_sel;
	logic [3:0] gwe_sel;
	logic [3:0] lock_sel;
	logic [3:0] match_raw;
	logic [3:0] match_sel;
	logic       pipe_on;
	logic       cal_io;

	assign gts_sel   = ctrl_q[startup_seq_pkg::GTS_LSB +: 4];
	assign gwe_sel   = ctrl_q[startup_seq_pkg::GWE_LSB +: 4];
	assign lock_sel  = {1'b0, ctrl_q[startup_seq_pkg::LOCK_LSB +: 3]};
	assign match_raw = ctrl_q[startup_seq_pkg::MATCH_LSB +: 4];
	assign pipe_on   = ctrl_q[startup_seq_pkg::PIPE_BIT];
	assign cal_io    = ctrl_q[startup_seq_pkg::CALIO_BIT];

	always_comb begin
		done_sel = ctrl_q[startup_seq_pkg::DONE_LSB +: 3];
		if (done_sel == startup_seq_pkg::PHASE_FIRST || done_sel == startup_seq_pkg::PHASE_END) begin
			done_sel = startup_seq_pkg::DONE_DFLT;
		end
		match_sel = match_raw;
		if (match_raw == startup_seq_pkg::SEL_AUTO) begin
			match_sel = cal_io ? startup_seq_pkg::AUTO_MATCH : startup_seq_pkg::SEL_NO_STALL_OPTION;
		end else if (match_raw > startup_seq_pkg::SEL_AUTO) begin
			match_sel = startup_seq_pkg::SEL_NO_STALL_OPTION;
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	startup_seq_pkg::seq_state_t state_q;
	startup_seq_pkg::seq_state_t state_d;
	logic [2:0] phase_q;
	logic [2:0] phase_d;
	logic       lock_stall;
	logic       match_stall;
	logic       done_hit;
	logic       done_d;
	logic       gts_rel_d;
	logic       gwe_d;
	logic       running;

	assign running     = (state_q != startup_seq_pkg::SEQ_IDLE);
	assign lock_stall  = (state_q == startup_seq_pkg::SEQ_RUN) && lock_sel != startup_seq_pkg::SEL_NO_STALL_OPTION
		&& {1'b0, phase_q} == lock_sel && !lock_s;
	assign match_stall = (state_q == startup_seq_pkg::SEQ_RUN) && match_sel != startup_seq_pkg::SEL_NO_STALL_OPTION
		&& {1'b0, phase_q} == match_sel && !match_s;
	assign done_hit    = running && phase_q >= done_sel;

	always_comb begin
		state_d   = state_q;
		phase_d   = phase_q;
		done_d    = o_done;
		gts_rel_d = ~o_io_tristate;
		gwe_d     = o_write_enable;
		unique case (state_q)
			startup_seq_pkg::SEQ_IDLE: begin
			end
			startup_seq_pkg::SEQ_RUN: begin
				if (tick && !lock_stall && !match_stall) begin
					phase_d = phase_q + 3'h1;
					if (phase_q == startup_seq_pkg::PHASE_LAST) begin
						state_d = startup_seq_pkg::SEQ_COMPLETE;
					end
				end
			end
			startup_seq_pkg::SEQ_COMPLETE: begin
			end
			default: begin
				state_d = startup_seq_pkg::SEQ_IDLE;
			end
		endcase
		if (pipe_on) begin
			done_d = o_done | (done_hit & tick);
		end else begin
			done_d = o_done | done_hit;
		end
		if (running) begin
			gts_rel_d = gts_rel_d | sel_reached(gts_sel, phase_q, o_done);
			gwe_d     = gwe_d | sel_reached(gwe_sel, phase_q, o_done);
		end
		if (start) begin
			state_d   = startup_seq_pkg::SEQ_RUN;
			phase_d   = startup_seq_pkg::PHASE_FIRST;
			done_d    = 1'b0;
			gts_rel_d = 1'b0;
			gwe_d     = 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			state_q        <= startup_seq_pkg::SEQ_IDLE;
			phase_q        <= startup_seq_pkg::PHASE_FIRST;
			o_done         <= 1'b0;
			o_io_tristate  <= 1'b1;
			o_write_enable <= 1'b0;
			o_bram_enable  <= 1'b0;
		end else begin
			state_q        <= state_d;
			phase_q        <= phase_d;
			o_done         <= done_d;
			o_io_tristate  <= ~gts_rel_d;
			o_write_enable <= gwe_d;
			o_bram_enable  <= gwe_d;
		end
	end

	always_comb begin
		status = 32'h0000_0000;
		status[startup_seq_pkg::ST_PHASE_LSB +: 3] = phase_q;
		status[startup_seq_pkg::ST_DONE_BIT]       = o_done;
		status[startup_seq_pkg::ST_GTS_BIT]        = ~o_io_tristate;
		status[startup_seq_pkg::ST_GWE_BIT]        = o_write_enable;
		status[startup_seq_pkg::ST_LOCK_BIT]       = lock_stall;
		status[startup_seq_pkg::ST_MATCH_BIT]      = match_stall;
		status[startup_seq_pkg::ST_STATE_LSB +: 2] = state_q;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);

	sequence s_stalled_tick;
		tick && (lock_stall || match_stall) && !start;
	endsequence

	done_phase_a: assert property (!pipe_on && done_hit && !start |=> o_done)
		else $error("done not raised at its phase");
	done_pipe_a: assert property (pipe_on && $rose(o_done) |-> $past(tick) && $past(done_hit))
		else $error("pipelined done rose off a clock tick");
	tristate_phase_a: assert property (running && !start
		&& gts_sel <= {1'b0, startup_seq_pkg::PHASE_LAST}
		&& {1'b0, phase_q} >= gts_sel |=> !o_io_tristate)
		else $error("io tristate not released at phase");
	write_en_a: assert property (running && !start
		&& gwe_sel <= {1'b0, startup_seq_pkg::PHASE_LAST}
		&& {1'b0, phase_q} >= gwe_sel |=> o_write_enable)
		else $error("write enable not asserted at phase");
	bram_gwe_a: assert property (o_bram_enable == o_write_enable)
		else $error("block ram enable differs from write enable");
	lock_stall_a: assert property (s_stalled_tick and lock_stall |=> $stable(phase_q))
		else $error("phase advanced while waiting for lock");
	match_stall_a: assert property (s_stalled_tick and match_stall
		|=> phase_q == $past(phase_q))
		else $error("phase advanced while waiting for match");
	auto_match_a: assert property (state_q == startup_seq_pkg::SEQ_RUN && !start
		&& match_raw == startup_seq_pkg::SEL_AUTO && cal_io && !match_s && tick
		&& {1'b0, phase_q} == startup_seq_pkg::AUTO_MATCH
		|=> {1'b0, phase_q} == startup_seq_pkg::AUTO_MATCH)
		else $error("auto match wait not in phase 2");
	advance_a: assert property (state_q == startup_seq_pkg::SEQ_RUN && tick && !lock_stall
		&& !match_stall && !start |=> phase_q == 3'($past(phase_q) + 3'h1))
		else $error("phase did not advance on tick");
	keep_a: assert property (gts_sel == startup_seq_pkg::SEL_KEEP && o_io_tristate
		&& $stable(ctrl_q) |=> o_io_tristate)
		else $error("keep option released tristate");
	done_tie_a: assert property (running && gwe_sel == startup_seq_pkg::SEL_DONE
		&& $rose(o_done) && !start |=> o_write_enable)
		else $error("write enable not tied to done");

endmodule

// ===== verif/cclk_source.sv
// Purpose: configuration source that drives the configuration clock
// Assumes: the bench raises i_run while it wants startup phases
// Notes:   the clock finishes its high half, then stands low when idle
`timescale 1ns/10ps
module cclk_source #(
	parameter int HALF = 4
) (
	input  wire logic i_mclk,
	input  wire logic i_run,
	output logic      o_cclk
);
	int div_q = 0;

	initial o_cclk = 1'b0;

	// ----------------------------------------------------------------
	// clock divider, halves of HALF system clocks
	// ----------------------------------------------------------------
	always @(posedge i_mclk) begin
		if (i_run || o_cclk) begin
			div_q <= (div_q == HALF - 1) ? 0 : div_q + 1;
			if (div_q == HALF - 1)
				o_cclk <= ~o_cclk;
		end else
			div_q <= 0;
	end
endmodule

// ===== verif/test_config_startup_sequencer.sv
// Purpose: self-checking bench for the startup sequencer
// Assumes: config clock from cclk_source, lock and match driven here
// Notes:   the phase of an event is the count of config clock ticks
`timescale 1ns/10ps
module test_config_startup_sequencer;
	localparam int NEV = 99;
	localparam int LIMIT = 5000;
	logic        i_mclk, i_reset, i_lock, i_match, i_read, i_write, run;
	logic [3:0]  i_address, i_byteenable;
	logic [31:0] i_writedata, o_readdata;
	logic        o_waitrequest, o_done, o_io_tristate, o_write_enable, o_bram_enable;
	wire         cclk;
	int          err_count = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          ticks, done_at, gts_at, gwe_at;

	config_startup_sequencer u_config_startup_sequencer (
		.i_mclk(i_mclk), .i_reset(i_reset), .i_cclk(cclk), .i_lock(i_lock),
		.i_match(i_match), .i_address(i_address), .i_read(i_read), .i_write(i_write),
		.i_writedata(i_writedata), .i_byteenable(i_byteenable),
		.o_waitrequest(o_waitrequest), .o_readdata(o_readdata), .o_done(o_done),
		.o_io_tristate(o_io_tristate), .o_write_enable(o_write_enable),
		.o_bram_enable(o_bram_enable));

	cclk_source u_cclk_source (.i_mclk(i_mclk), .i_run(run), .o_cclk(cclk));

	initial begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end

	// ----------------------------------------------------------------
	// event monitor and timeout
	// ----------------------------------------------------------------
	always @(posedge cclk) ticks++;

	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (o_done === 1'b1 && done_at == NEV) done_at = ticks;
		if (o_io_tristate === 1'b0 && gts_at == NEV) gts_at = ticks;
		if (o_write_enable === 1'b1 && gwe_at == NEV) gwe_at = ticks;
		if (run) check(32'(o_bram_enable), 32'(o_write_enable));
		if (cyc == LIMIT) begin
			err_count++;
			results();
		end
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t ns: seen 0x%h expected 0x%h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		@(posedge i_mclk);
		i_address <= a;
		i_writedata <= d;
		i_byteenable <= be;
		i_write <= wr;
		i_read <= !wr;
		// hold until waitrequest is sampled low at a rising edge
		do begin
			@(posedge i_mclk);
		end while (o_waitrequest !== 1'b0);
		q = o_readdata;
		i_write <= 1'b0;
		i_read <= 1'b0;
	endtask

	task automatic spin(input int n);
		ticks = 0;
		done_at = NEV;
		gts_at = NEV;
		gwe_at = NEV;
		run <= 1'b1;
		while (ticks < n) begin
			@(posedge i_mclk);
		end
		run <= 1'b0;
		repeat (12) @(posedge i_mclk);
	endtask

	task automatic go(input logic [31:0] ctrl, input int n);
		logic [31:0] q;
		bus(1'b1, 4'h0, ctrl | 32'h0100_0000, 4'hf, q);
		repeat (2) @(posedge i_mclk);
		check(32'({o_done, o_io_tristate, o_write_enable}), 32'h0000_0002);
		spin(n);
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		logic [31:0] q;
		check(32'({o_waitrequest, o_done, o_io_tristate, o_write_enable}), 32'h0000_000a);
		bus(1'b0, 4'h0, 32'h0000_0000, 4'hf, q);
		check(q, 32'h0008_7654);
		bus(1'b1, 4'h8, 32'hffff_ffff, 4'hf, q);
		bus(1'b0, 4'h8, 32'h0000_0000, 4'hf, q);
		check(q, 32'h0000_0000);
		bus(1'b1, 4'h0, 32'h0100_0001, 4'h1, q);
		bus(1'b0, 4'h0, 32'h0000_0000, 4'hf, q);
		check(q, 32'h0008_7601);
		bus(1'b0, 4'h4, 32'h0000_0000, 4'hf, q);
		check(q, 32'h0000_0000);
		$display("test reset finished");
	endtask

	task automatic t_phases;
		logic [31:0] c [4] = '{32'h0008_7654, 32'h0007_7871, 32'h0017_7726, 32'h0007_7380};
		int e [4][3] = '{'{4, 5, 6}, '{1, 1, NEV}, '{7, 2, 7}, '{4, NEV, 3}};
		logic [31:0] q;
		for (int i = 0; i < 4; i++) begin
			go(c[i], 9);
			check(32'(done_at), 32'(e[i][0]));
			check(32'(gts_at), 32'(e[i][1]));
			check(32'(gwe_at), 32'(e[i][2]));
			bus(1'b0, 4'h4, 32'h0000_0000, 4'hf, q);
			check(q & 32'h0000_0c07, 32'h0000_0807);
		end
		$display("test phases finished");
	endtask

	task automatic stall(input logic [31:0] ctrl, input int ph, input logic use_m);
		logic [31:0] q;
		go(ctrl, 8);
		bus(1'b0, 4'h4, 32'h0000_0000, 4'hf, q);
		check(q & 32'h0000_0187, (use_m ? 32'h0000_0100 : 32'h0000_0080) | 32'(ph));
		check(32'(gwe_at), 32'(NEV));
		if (use_m)
			i_match <= 1'b1;
		else
			i_lock <= 1'b1;
		repeat (6) @(posedge i_mclk);
		spin(8);
		check(32'(done_at), 32'((ph < 4) ? 4 - ph : 0));
		check(32'(gwe_at), 32'(6 - ph));
		bus(1'b0, 4'h4, 32'h0000_0000, 4'hf, q);
		check(q & 32'h0000_0187, 32'h0000_0007);
		i_lock <= 1'b0;
		i_match <= 1'b0;
		$display("test stall at phase %0d finished", ph);
	endtask

	initial begin
		i_reset = 1'b1;
		i_lock = 1'b0;
		i_match = 1'b0;
		i_read = 1'b0;
		i_write = 1'b0;
		run = 1'b0;
		i_address = 4'h0;
		i_byteenable = 4'hf;
		i_writedata = 32'h0000_0000;
		ticks = 0;
		repeat (3) @(posedge i_mclk);
		i_reset <= 1'b0;
		@(posedge i_mclk);
		t_reset();
		t_phases();
		stall(32'h0007_0654, 0, 1'b0);
		stall(32'h0005_7654, 5, 1'b1);
		stall(32'h0028_7654, 2, 1'b1);
		results();
	end
endmodule
